// ===== rtl/drp_top.sv
// Burst read data path: Wishbone mode registers and link-side burst engine
// What this block does
// - Burst start column comes from CA; two low column bits are zero.
// - Latency counts from the second edge of the CAS-2 part.
// - First data comes read latency clock periods after the completing edge.
// - Strobe is driven one preamble interval before its first valid rising edge.
// - First beat sits on the first rising strobe edge after the preamble.
// - Each later beat follows edge-aligned, one beat per strobe edge.
// - Postamble is half a cycle, or one and a half in extended mode.
// - Read latency comes from the programmed mode setting, raised to at least three cycles.
// - Mode register 1 bit 3 picks static or toggling preamble.
// - Mode register 1 bit 7 picks half or one and a half cycle postamble.
// - With on-the-fly length on, first part's bit picks 32 or 16 beats.
`timescale 1ns/1ps
`default_nettype none
module drp_top (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  input  wire logic                  link_ck,
  input  wire drp_pkg::drp_cmd_type  link_cmd,
  output drp_pkg::drp_pins_type      link_pins
);

  // Reference clock domain state
  logic [5:0]            rl_reg;
  logic                  otf_en;
  logic                  bl32_fixed;
  logic                  pre_toggle;
  logic                  post_ext;
  logic [15:0]           read_count;
  logic [1:0]            back_sync;
  logic                  done_seen;
  logic                  req;
  logic                  mapped;
  logic [31:0]           next_rdata;
  drp_pkg::drp_cfg_type  cfg_ref;

  // Link clock domain state
  typedef enum logic [2:0] {ENG_IDLE, ENG_LAT, ENG_PRE0, ENG_PRE1, ENG_DATA, ENG_POSTX, ENG_POSTL}
    drp_eng_type;

  logic [9:0]            cfg_ck_bits;
  drp_pkg::drp_cfg_type  cfg_ck;
  logic                  ck_rst;
  logic                  ck_ce;
  logic [1:0]            ck_ctl;
  logic                  issue;
  logic [9:0]            issue_col;
  logic                  bl_bit;
  drp_eng_type           state;
  drp_eng_type           next_state;
  logic [5:0]            cnt;
  logic [5:0]            next_cnt;
  logic [4:0]            pair;
  logic [4:0]            next_pair;
  logic [4:0]            pairs;
  logic [4:0]            next_pairs;
  logic [9:0]            col;
  logic [9:0]            next_col;
  logic                  pre_tog_q;
  logic                  post_ext_q;
  logic [5:0]            rl_eff;
  logic                  busy;
  logic                  done_tgl;
  drp_pkg::drp_pins_type next_pins;

  // Wishbone slave, one-cycle registered answer

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = wb_adr_i == drp_pkg::REG_RLCFG || wb_adr_i == drp_pkg::REG_MR1 ||
                  wb_adr_i == drp_pkg::REG_STAT;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      drp_pkg::REG_RLCFG:
      begin
        next_rdata[drp_pkg::RLCFG_RL_MSB:drp_pkg::RLCFG_RL_LSB] = rl_reg;
        next_rdata[drp_pkg::RLCFG_OTF_BIT]  = otf_en;
        next_rdata[drp_pkg::RLCFG_BL32_BIT] = bl32_fixed;
      end
      drp_pkg::REG_MR1:
      begin
        next_rdata[drp_pkg::MR1_PRE_BIT]  = pre_toggle;
        next_rdata[drp_pkg::MR1_POST_BIT] = post_ext;
      end
      drp_pkg::REG_STAT:
      begin
        next_rdata[drp_pkg::STAT_CNT_MSB:drp_pkg::STAT_CNT_LSB] = read_count;
        next_rdata[drp_pkg::STAT_BUSY_BIT] = back_sync[0];
      end
      default:
      begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && mapped && !wb_we_i) ? next_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rl_reg     <= drp_pkg::RL_RESET;
      otf_en     <= 1'b0;
      bl32_fixed <= 1'b0;
      pre_toggle <= 1'b0;
      post_ext   <= 1'b0;
    end
    else if (ce && req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == drp_pkg::REG_RLCFG)
      begin
        rl_reg <= wb_dat_i[drp_pkg::RLCFG_RL_MSB:drp_pkg::RLCFG_RL_LSB];
      end
      if (wb_adr_i == drp_pkg::REG_MR1)
      begin
        pre_toggle <= wb_dat_i[drp_pkg::MR1_PRE_BIT];
        post_ext   <= wb_dat_i[drp_pkg::MR1_POST_BIT];
      end
    end
    if (!rst && ce && req && wb_we_i && wb_sel_i[1] && wb_adr_i == drp_pkg::REG_RLCFG)
    begin
      otf_en     <= wb_dat_i[drp_pkg::RLCFG_OTF_BIT];
      bl32_fixed <= wb_dat_i[drp_pkg::RLCFG_BL32_BIT];
    end
  end

  // Completed bursts counted from the synchronised done toggle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      done_seen  <= 1'b0;
      read_count <= drp_pkg::CNT_RESET;
    end
    else if (ce)
    begin
      done_seen <= back_sync[1];
      if (back_sync[1] != done_seen)
      begin
        read_count <= read_count + 16'h0001;
      end
    end
  end

  // Domain crossings
  // Mode bits cross as quasi-static levels; change them only while idle
  assign cfg_ref = '{rl_reg, otf_en, bl32_fixed, pre_toggle, post_ext};

  drp_sync #(.WIDTH(drp_pkg::CFG_W)) u_cfg_sync (
    .clk (link_ck),
    .d   (cfg_ref),
    .q   (cfg_ck_bits)
  );

  drp_sync #(.WIDTH(2)) u_ctl_sync (
    .clk (link_ck),
    .d   ({rst, ce}),
    .q   (ck_ctl)
  );

  drp_sync #(.WIDTH(2)) u_back_sync (
    .clk (ref_clk),
    .d   ({done_tgl, busy}),
    .q   (back_sync)
  );

  assign cfg_ck = cfg_ck_bits;
  assign ck_rst = ck_ctl[1];
  assign ck_ce  = ck_ctl[0];

  drp_ca_decode u_decode (
    .ck     (link_ck),
    .ck_rst (ck_rst),
    .ck_ce  (ck_ce),
    .cmd    (link_cmd),
    .issue  (issue),
    .column (issue_col),
    .bl_bit (bl_bit)
  );

  // Burst engine on the link clock
  // Latencies below the two preamble cycles plus one are raised to the minimum
  assign rl_eff = (cfg_ck.rl < drp_pkg::RL_MIN) ? drp_pkg::RL_MIN : cfg_ck.rl;

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_pair  = pair;
    next_pairs = pairs;
    next_col   = col;
    next_pins  = drp_pkg::PINS_IDLE;
    unique case (state)
      ENG_IDLE:
      begin
        // Burst interrupts are not allowed, so commands arrive only while idle
        if (issue)
        begin
          next_state = ENG_LAT;
          next_cnt   = rl_eff - drp_pkg::RL_MIN;
          next_col   = issue_col;
          if (cfg_ck.otf_en ? bl_bit : cfg_ck.bl32)
          begin
            next_pairs = drp_pkg::PAIRS_BL32;
          end
          else
          begin
            next_pairs = drp_pkg::PAIRS_BL16;
          end
        end
      end
      ENG_LAT:
      begin
        if (cnt == 6'h00)
        begin
          next_state       = ENG_PRE0;
          next_pins.dqs_oe = drp_pkg::OE_FULL;
          next_pins.dqs    = drp_pkg::DQS_LOW;
        end
        else
        begin
          next_cnt = cnt - 6'h01;
        end
      end
      ENG_PRE0:
      begin
        next_state       = ENG_PRE1;
        next_pins.dqs_oe = drp_pkg::OE_FULL;
        next_pins.dqs    = pre_tog_q ? drp_pkg::DQS_HI_LO : drp_pkg::DQS_LOW;
        next_pair        = 5'h00;
      end
      ENG_PRE1, ENG_DATA:
      begin
        if (state == ENG_DATA && pair == pairs)
        begin
          next_state       = post_ext_q ? ENG_POSTX : ENG_POSTL;
          next_pins.dqs_oe = post_ext_q ? drp_pkg::OE_FULL : drp_pkg::OE_FIRST;
          next_pins.dqs    = post_ext_q ? drp_pkg::DQS_HI_LO : drp_pkg::DQS_LOW;
        end
        else
        begin
          // Beat pair on the rising then falling strobe edge
          next_state        = ENG_DATA;
          next_pins.dqs_oe  = drp_pkg::OE_FULL;
          next_pins.dqs     = drp_pkg::DQS_HI_LO;
          next_pins.dq_oe   = 1'b1;
          next_pins.dq_rise = {6'h00, col} + {10'h000, pair, 1'b0};
          next_pins.dq_fall = {6'h00, col} + {10'h000, pair, 1'b1};
          next_pair         = pair + 5'h01;
        end
      end
      ENG_POSTX:
      begin
        next_state       = ENG_POSTL;
        next_pins.dqs_oe = drp_pkg::OE_FIRST;
        next_pins.dqs    = drp_pkg::DQS_LOW;
      end
      ENG_POSTL:
      begin
        next_state = ENG_IDLE;
      end
      default:
      begin
        // Unused state code falls back to idle with the lines released
        next_state = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_ck)
  begin
    if (ck_rst)
    begin
      state      <= ENG_IDLE;
      cnt        <= 6'h00;
      pair       <= 5'h00;
      pairs      <= drp_pkg::PAIRS_BL16;
      col        <= 10'h000;
      link_pins  <= drp_pkg::PINS_IDLE;
      busy       <= 1'b0;
    end
    else if (ck_ce)
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      pair      <= next_pair;
      pairs     <= next_pairs;
      col       <= next_col;
      link_pins <= next_pins;
      busy      <= next_state != ENG_IDLE;
    end
  end

  // Framing options are latched per burst so a mode change cannot split one
  always_ff @(posedge link_ck)
  begin
    if (ck_rst)
    begin
      pre_tog_q  <= 1'b0;
      post_ext_q <= 1'b0;
    end
    else if (ck_ce && state == ENG_IDLE && issue)
    begin
      pre_tog_q  <= cfg_ck.pre_toggle;
      post_ext_q <= cfg_ck.post_ext;
    end
  end

  always_ff @(posedge link_ck)
  begin
    if (ck_rst)
    begin
      done_tgl <= 1'b0;
    end
    else if (ck_ce && state == ENG_POSTL)
    begin
      done_tgl <= !done_tgl;
    end
  end

endmodule // drp_top
`default_nettype wire

// ===== rtl/drp_pkg.sv
// Shared constants and carriers of the burst read data path
package drp_pkg;

  // Register byte addresses on the Wishbone slave
  localparam logic [7:0] REG_RLCFG = 8'h00;
  localparam logic [7:0] REG_MR1   = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;

  // Field positions
  localparam int RLCFG_RL_LSB   = 0;
  localparam int RLCFG_RL_MSB   = 5;
  localparam int RLCFG_OTF_BIT  = 8;
  localparam int RLCFG_BL32_BIT = 9;
  localparam int MR1_PRE_BIT    = 3;
  localparam int MR1_POST_BIT   = 7;
  localparam int STAT_CNT_LSB   = 0;
  localparam int STAT_CNT_MSB   = 15;
  localparam int STAT_BUSY_BIT  = 16;

  // Reset values and limits
  localparam logic [5:0]  RL_RESET   = 6'h0E;
  localparam logic [5:0]  RL_MIN     = 6'h03;
  localparam logic [15:0] CNT_RESET  = 16'h0000;

  // Command encodings on the low five command/address lines, first edge
  localparam logic [4:0] CMD_READ1 = 5'h02;
  localparam logic [4:0] CMD_CAS2  = 5'h12;

  // Beat pairs per burst, two beats per clock
  localparam logic [4:0] PAIRS_BL16 = 5'h08;
  localparam logic [4:0] PAIRS_BL32 = 5'h10;

  // Strobe level and enable per half cycle, first half in the upper bit
  localparam logic [1:0] DQS_LOW   = 2'h0;
  localparam logic [1:0] DQS_HI_LO = 2'h2;
  localparam logic [1:0] OE_NONE   = 2'h0;
  localparam logic [1:0] OE_FIRST  = 2'h2;
  localparam logic [1:0] OE_FULL   = 2'h3;

  localparam int CFG_W = 10;

  typedef struct packed {
    logic [5:0] rl;
    logic       otf_en;
    logic       bl32;
    logic       pre_toggle;
    logic       post_ext;
  } drp_cfg_type;

  typedef struct packed {
    logic       cke;
    logic       cs;
    logic [5:0] ca;
  } drp_cmd_type;

  typedef struct packed {
    logic [15:0] dq_rise;
    logic [15:0] dq_fall;
    logic        dq_oe;
    logic [1:0]  dqs;
    logic [1:0]  dqs_oe;
  } drp_pins_type;

  localparam drp_pins_type PINS_IDLE = '{16'h0000, 16'h0000, 1'b0, 2'h0, 2'h0};

endpackage

// ===== rtl/drp_sync.sv
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
`default_nettype none
module drp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_lane
      // First stage feeds only the second
      always_ff @(posedge clk)
      begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  endgenerate

endmodule // drp_sync
`default_nettype wire

// ===== rtl/drp_ca_decode.sv
// Read command capture on the command/address bus, link clock domain
`timescale 1ns/1ps
`default_nettype none
module drp_ca_decode (
  input  wire logic                 ck,
  input  wire logic                 ck_rst,
  input  wire logic                 ck_ce,
  input  wire drp_pkg::drp_cmd_type cmd,
  output logic                      issue,
  output logic [9:0]                column,
  output logic                      bl_bit
);

  typedef enum logic [1:0] {DEC_IDLE, DEC_RD1B, DEC_CAS2A, DEC_CAS2B} drp_dec_type;

  drp_dec_type state;
  logic        c9;
  logic        c8;

  always_ff @(posedge ck)
  begin
    if (ck_rst)
    begin
      state  <= DEC_IDLE;
      c9     <= 1'b0;
      c8     <= 1'b0;
      bl_bit <= 1'b0;
    end
    else if (ck_ce)
    begin
      unique case (state)
        DEC_IDLE:
        begin
          if (cmd.cke && cmd.cs && cmd.ca[4:0] == drp_pkg::CMD_READ1)
          begin
            bl_bit <= cmd.ca[5];
            state  <= DEC_RD1B;
          end
        end
        DEC_RD1B:
        begin
          c9    <= cmd.ca[5];
          state <= DEC_CAS2A;
        end
        DEC_CAS2A:
        begin
          // Anything but CAS-2 right after READ-1 drops the command
          if (cmd.cke && cmd.cs && cmd.ca[4:0] == drp_pkg::CMD_CAS2)
          begin
            c8    <= cmd.ca[5];
            state <= DEC_CAS2B;
          end
          else
          begin
            state <= DEC_IDLE;
          end
        end
        DEC_CAS2B:
        begin
          state <= DEC_IDLE;
        end
      endcase
    end
  end

  // Issue marks the edge that completes the read
  assign issue  = ck_ce && state == DEC_CAS2B;
  assign column = {c9, c8, cmd.ca, 2'b00};

endmodule // drp_ca_decode
`default_nettype wire

// ===== testbench/drp_assertions.sv
// Port checker for the burst read path
`timescale 1ns/1ps
`default_nettype none
module drp_assertions (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic                  wb_err_o,
  input wire logic                  link_ck,
  input wire drp_pkg::drp_pins_type link_pins
);
  wb_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_cyc_i && wb_stb_i && ce && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o) else $error("no bus answer");
  ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  data_strobe_a: assert property (@(posedge link_ck) disable iff (rst) link_pins.dq_oe |->
    link_pins.dqs_oe == drp_pkg::OE_FULL && link_pins.dqs == drp_pkg::DQS_HI_LO) else $error("strobe off in data");
  beat_pair_a: assert property (@(posedge link_ck) disable iff (rst) link_pins.dq_oe |->
    link_pins.dq_fall == link_pins.dq_rise + 16'h0001) else $error("falling beat wrong");
  burst_start_a: assert property (@(posedge link_ck) disable iff (rst) $rose(link_pins.dq_oe) |->
    link_pins.dq_rise[1:0] == 2'h0 && $past(link_pins.dqs_oe) == drp_pkg::OE_FULL
    && $past(link_pins.dqs_oe, 2) == drp_pkg::OE_FULL) else $error("bad burst start");
  beat_step_a: assert property (@(posedge link_ck) disable iff (rst)
    link_pins.dq_oe && $past(link_pins.dq_oe) |-> link_pins.dq_rise == $past(link_pins.dq_rise) + 16'h0002)
    else $error("beat order broken");
  burst_len_a: assert property (@(posedge link_ck) disable iff (rst)
    $rose(link_pins.dq_oe) |-> link_pins.dq_oe[*8]) else $error("burst too short");
  post_hold_a: assert property (@(posedge link_ck) disable iff (rst)
    $fell(link_pins.dq_oe) |-> link_pins.dqs_oe != drp_pkg::OE_NONE) else $error("no postamble");
  idle_after_a: assert property (@(posedge link_ck) disable iff (rst)
    !link_pins.dq_oe && link_pins.dqs_oe == drp_pkg::OE_FIRST |=> link_pins == drp_pkg::PINS_IDLE)
    else $error("lines not released");
  burst_seen_c: cover property (@(posedge link_ck) $rose(link_pins.dq_oe));
  long_burst_c: cover property (@(posedge link_ck) link_pins.dq_oe[*8] ##1 link_pins.dq_oe[*8]);
  bus_err_c: cover property (@(posedge ref_clk) wb_err_o);
endmodule // drp_assertions
bind drp_top drp_assertions i_drp_assertions (.ref_clk(ref_clk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .link_ck(link_ck), .link_pins(link_pins));
`default_nettype wire

// ===== testbench/drp_ctrl_model.sv
// Controller model: issues reads on the command bus and captures bursts
`timescale 1ns/1ps
`default_nettype none
module drp_ctrl_model (
  input  wire logic                  link_ck,
  output drp_pkg::drp_cmd_type       link_cmd,
  input  wire drp_pkg::drp_pins_type link_pins
);
  initial link_cmd = '{1'b1, 1'b0, 6'h2A};

  task automatic send(input logic cs, input logic [5:0] ca);
    @(posedge link_ck);
    link_cmd <= '{1'b1, cs, ca};
  endtask

  // Counts link cycles after the completing edge; abort drops the second part
  task automatic read(input logic [9:0] col, input logic bl, input logic tog, input logic abort,
                      output logic [31:0] lat, output logic [31:0] pairs, output logic [31:0] post,
                      output logic [31:0] bad);
    drp_pkg::drp_pins_type prev;
    logic [15:0]           beat;
    lat = 0;
    pairs = 0;
    post = 0;
    bad = 0;
    beat = {6'h00, col};
    prev = drp_pkg::PINS_IDLE;
    send(1'b1, {bl, drp_pkg::CMD_READ1});
    send(1'b0, {col[9], 5'h00});
    send(!abort, {col[8], drp_pkg::CMD_CAS2});
    send(1'b0, col[7:2]);
    send(1'b0, ~col[7:2]);
    for (int n = 1; n < 80; n++)
    begin
      @(posedge link_ck);
      // Deselected lines keep moving so a stale value cannot pass
      link_cmd.ca <= ~link_cmd.ca;
      #1;
      if (link_pins.dq_oe)
      begin
        if (pairs == 0)
        begin
          lat = n;
          if (prev.dqs !== (tog ? drp_pkg::DQS_HI_LO : drp_pkg::DQS_LOW)) bad++;
        end
        if (link_pins.dq_rise !== beat || link_pins.dq_fall !== beat + 16'h0001) bad++;
        beat += 16'h0002;
        pairs++;
      end
      else if (link_pins.dqs_oe !== drp_pkg::OE_NONE && pairs != 0) post++;
      prev = link_pins;
    end
  endtask
endmodule // drp_ctrl_model
`default_nettype wire

// ===== testbench/tb.sv
// Testbench: mode registers over Wishbone, read bursts through the controller model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                  ref_clk = 1'b0;
  logic                  link_ck = 1'b0;
  logic                  rst = 1'b1;
  logic                  wb_cyc_i = 1'b0;
  logic                  wb_stb_i = 1'b0;
  logic                  wb_we_i = 1'b0;
  logic [7:0]            wb_adr_i = 8'h00;
  logic [31:0]           wb_dat_i = 32'h00000000;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  logic                  wb_err_o;
  drp_pkg::drp_cmd_type  link_cmd;
  drp_pkg::drp_pins_type link_pins;
  logic [31:0]           rd, lat, pairs, pst, bad;
  logic                  er;
  int                    err_total = 0;
  int                    compares = 0;
  int                    cycles = 0;
  logic [5:0]            rlv [4] = '{6'h03, 6'h01, 6'h06, 6'h0E};
  logic [9:0]            col [4] = '{10'h3FC, 10'h004, 10'h008, 10'h00C};
  logic [3:0]            otf = 4'hA;
  logic [3:0]            blr = 4'h4;
  logic [3:0]            blb = 4'h3;
  logic [3:0]            pre = 4'hA;
  logic [3:0]            post = 4'h6;

  always #2.5 ref_clk = ~ref_clk;
  initial
  begin
    #7;
    forever #24 link_ck = ~link_ck;
  end

  drp_top i_drp_top (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .link_ck(link_ck), .link_cmd(link_cmd), .link_pins(link_pins));
  drp_ctrl_model i_drp_ctrl_model (.link_ck(link_ck), .link_cmd(link_cmd), .link_pins(link_pins));

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    // An ack or err ends the wait for the answer; the cycle ceiling catches a missing one
    do
    begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_total++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (6) @(posedge link_ck);
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge link_ck);
    wb(1'b0, drp_pkg::REG_RLCFG, 32'h0);
    check(rd, {26'h0000000, drp_pkg::RL_RESET});
    wb(1'b0, drp_pkg::REG_MR1, 32'h0);
    check(rd, 32'h00000000);
    wb(1'b1, drp_pkg::REG_STAT, 32'hFFFFFFFF);
    wb(1'b0, drp_pkg::REG_STAT, 32'h0);
    check(rd, 32'h00000000);
    wb(1'b0, 8'h0C, 32'h0);
    check(er, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, drp_pkg::REG_RLCFG, {22'h000000, blr[i], otf[i], 2'h0, rlv[i]});
      wb(1'b1, drp_pkg::REG_MR1, {24'h000000, post[i], 3'h0, pre[i], 3'h0});
      // Mode levels need a few link cycles to cross
      repeat (4) @(posedge link_ck);
      i_drp_ctrl_model.read(col[i], blb[i], pre[i], 1'b0, lat, pairs, pst, bad);
      check(lat, rlv[i] < 6'h03 ? 32'h3 : {26'h0000000, rlv[i]});
      check(pairs, (otf[i] ? blb[i] : blr[i]) ? 32'h10 : 32'h8);
      check(pst, post[i] ? 32'h2 : 32'h1);
      check(bad, 32'h0);
    end
    i_drp_ctrl_model.read(10'h010, 1'b0, 1'b1, 1'b1, lat, pairs, pst, bad);
    check(pairs, 32'h0);
    wb(1'b0, drp_pkg::REG_STAT, 32'h0);
    check(rd, 32'h00000004);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
